// ==== src/interrupt_source_vector_priority.sv ====
// Interrupt source collection, vector assignment and priority with AXI4-Lite registers
// Summary of operation
// R1 - NMI is highest priority and ignores the CPU mask bits.
// R2 - NMI triggers on rising or falling pin edge per edge-select bit.
// R3 - Taking NMI presents vector number 7.
// R4 - NMI and external lines 0 and 1 wake from standby; lines 4, 5 do not.
// R5 - Each external line senses low level or falling edge per sense bit.
// R6 - External request forwarded only when its enable bit is set.
// R7 - Each external request shows in a pending flag; software clears by writing 0.
// R8 - External lines 0, 1, 4, 5 use vectors 12, 13, 16, 17.
// R9 - External requests are sensed whatever the pin direction.
// R10 - Software clears pin direction bit and keeps serial use off the pin.
// R11 - 25 internal requests arrive already enabled by their peripherals.
// R12 - Equal priority level ranks by smaller vector number first.
// R13 - Default order after reset; two priority registers change all but NMI.
// R14 - Line 0 uses A bit 7, line 1 bit 6, lines 4/5 bit 4.
// R15 - Watchdog vector 20 bit A3; timer 0 vectors 24-26 bit A2.
// R16 - Timer 1 vectors 28-30 bit A1; timer 2 vectors 32-34 bit A0.
// R17 - Timer 3 vectors 36-38 bit B7; timer 4 vectors 40-42 bit B6.
// R18 - Serial 0 four requests use vectors 52-55 with bit B3.
// R19 - Serial 1 vectors 56-59 bit B2; converter end vector 60 bit B1.
// R20 - Vector address is two bytes per entry normal, four advanced.
// R21 - Priority bit 1 is high level 1; 0, the reset value, is low.
// R22 - Pending flag clears on write 0 after read 1, or on exception.
// R23 - Simultaneous equal-setting requests resolve by default vector order.
// R24 - Reserved vector numbers are never selected.
`timescale 1ns/1ps
module interrupt_source_vector_priority
  import isvp_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // AXI4-Lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  // AXI4-Lite read data
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // External pins
  input  wire logic                nmi_pin,
  input  wire logic [EXT_LINES-1:0] irq_pin_n,
  // Internal requests, already gated by peripheral enables
  input  wire logic [NUM_INT-1:0]  periph_req,
  // CPU side
  input  wire logic                ccr_i_bit,
  input  wire logic                ccr_ui_bit,
  input  wire logic                advanced_mode,
  input  wire logic                exc_ack,
  input  wire logic [5:0]          exc_ack_vector,
  output logic                     cpu_irq_req,
  output logic                     cpu_irq_is_nmi,
  output logic [5:0]               cpu_irq_vector,
  output logic [15:0]              cpu_irq_vector_addr,
  output logic                     standby_wake
);

  // Registers
  logic [7:0]            system_control_reg_ff;
  logic [7:0]            irq_sense_control_reg_ff;
  logic [7:0]            irq_enable_reg_ff;
  logic [7:0]            priority_reg_a_ff;
  logic [7:0]            priority_reg_b_ff;
  logic [EXT_LINES-1:0]  seen_one_ff;
  logic                  nmi_prev_ff;
  logic                  nmi_pend_ff;

  // Bus slave state
  logic                  aw_held_ff;
  logic [7:0]            aw_addr_ff;
  logic                  w_held_ff;
  logic [7:0]            w_data_ff;
  logic                  w_lane0_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;

  // Registered CPU outputs
  logic                  irq_req_ff;
  logic                  irq_nmi_ff;
  logic [5:0]            irq_vec_ff;
  logic [15:0]           irq_addr_ff;
  logic                  wake_ff;

  // Shared decode: address maps onto a register
  function automatic logic addr_mapped(input logic [7:0] a);
    return a == OFS_SYSCTL || a == OFS_SENSE || a == OFS_ENABLE || a == OFS_PENDING ||
           a == OFS_PRIO_A || a == OFS_PRIO_B || a == OFS_VECTOR;
  endfunction : addr_mapped

  // Write channel: address and data taken in either order
  wire        wr_fire    = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire        wr_ok      = wr_fire & addr_mapped(aw_addr_ff);
  wire        wr_en      = wr_ok & w_lane0_ff;
  wire        wr_sysctl  = wr_en && aw_addr_ff == OFS_SYSCTL;
  wire        wr_sense   = wr_en && aw_addr_ff == OFS_SENSE;
  wire        wr_enable  = wr_en && aw_addr_ff == OFS_ENABLE;
  wire        wr_pending = wr_en && aw_addr_ff == OFS_PENDING;
  wire        wr_prio_a  = wr_en && aw_addr_ff == OFS_PRIO_A;
  wire        wr_prio_b  = wr_en && aw_addr_ff == OFS_PRIO_B;

  assign s_axi_awready = ~aw_held_ff;
  assign s_axi_wready  = ~w_held_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // Read channel: one read outstanding
  wire        rd_fire    = s_axi_arvalid & ~rvalid_ff;
  wire        rd_pending = rd_fire && s_axi_araddr == OFS_PENDING;

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_ff  <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control registers; reserved bits hold zero, except that the sense register keeps all 8 bits writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_control_reg_ff    <= SYSCTL_RST;
      irq_sense_control_reg_ff <= REG_RST;
      irq_enable_reg_ff        <= REG_RST;
      priority_reg_a_ff        <= REG_RST; // R13 R21
      priority_reg_b_ff        <= REG_RST; // R13 R21
    end else begin
      if (wr_sysctl) system_control_reg_ff    <= w_data_ff & SYSCTL_MASK;
      if (wr_sense)  irq_sense_control_reg_ff <= w_data_ff & SENSE_MASK;
      if (wr_enable) irq_enable_reg_ff        <= w_data_ff & IRQ_MASK;
      if (wr_prio_a) priority_reg_a_ff        <= w_data_ff & PRIO_A_MASK; // R13
      if (wr_prio_b) priority_reg_b_ff        <= w_data_ff & PRIO_B_MASK; // R13
    end
  end

  // External lines
  logic [EXT_LINES-1:0] ext_flag;
  logic [EXT_LINES-1:0] ext_sw_clear;
  logic [EXT_LINES-1:0] ext_exc_clear;
  logic [EXT_LINES-1:0] ext_enabled;

  generate
    for (genvar g = 0; g < EXT_LINES; g++) begin : g_ext
      // Clear by write 0 only after this bit was read as 1
      assign ext_sw_clear[g]  = wr_pending & ~w_data_ff[EXT_BIT[g]] & seen_one_ff[g]; // R22
      assign ext_exc_clear[g] = exc_ack && exc_ack_vector == src_vector(IDX_W'(g + 1)); // R22
      assign ext_enabled[g]   = irq_enable_reg_ff[EXT_BIT[g]]; // R6

      ext_irq_line u_line (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .pin_n            (irq_pin_n[g]),
        .sense_edge       (irq_sense_control_reg_ff[EXT_BIT[g]]),
        .sw_clear         (ext_sw_clear[g]),
        .exc_clear        (ext_exc_clear[g]),
        .irq_pending_flag (ext_flag[g])
      );
    end
  endgenerate

  // Remember which flags software has seen set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_one_ff <= '0;
    end else if (rd_pending) begin
      seen_one_ff <= ext_flag;
    end else if (wr_pending) begin
      seen_one_ff <= seen_one_ff & ~ext_sw_clear;
    end
  end

  // NMI edge detection; pin direction is never consulted
  wire nmi_rise = nmi_pin & ~nmi_prev_ff;
  wire nmi_fall = ~nmi_pin & nmi_prev_ff;
  wire nmi_edge = system_control_reg_ff[SYS_NMI_EDGE_SELECT_BIT] ? nmi_rise : nmi_fall; // R2
  wire nmi_ack  = exc_ack && exc_ack_vector == NMI_VECTOR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_prev_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else begin
      nmi_prev_ff <= nmi_pin;
      nmi_pend_ff <= nmi_edge | (nmi_pend_ff & ~nmi_ack); // R2
    end
  end

  // Source vector in default order
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC-1:0] src_hi;
  logic [NUM_SRC-1:0] src_allowed;
  wire  [15:0]        prio_bits = {priority_reg_b_ff, priority_reg_a_ff};

  assign src_req[0] = nmi_pend_ff;
  assign src_req[FIRST_INT-1:1] = ext_flag & ext_enabled; // R6 R8
  assign src_req[NUM_SRC-1:FIRST_INT] = periph_req; // R11

  // Mode: UE set uses I only; UE clear lets level 1 through under I alone
  wire ue_bit = system_control_reg_ff[SYS_UE_BIT];
  wire lvl0_ok = ~ccr_i_bit;
  wire lvl1_ok = ~ccr_i_bit | (~ue_bit & ~ccr_ui_bit);

  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
      if (s == 0) begin : g_nmi
        assign src_hi[s]      = 1'b1;
        assign src_allowed[s] = 1'b1; // R1
      end else begin : g_mask
        assign src_hi[s]      = prio_bits[src_prio_sel(IDX_W'(s))]; // R14 R15 R16 R17 R18 R19 R21
        assign src_allowed[s] = src_hi[s] ? lvl1_ok : lvl0_ok;
      end
    end
  endgenerate

  logic             sel_hit;
  logic [IDX_W-1:0] sel_idx;

  irq_vector_select u_select (
    .req      (src_req),
    .level_hi (src_hi),
    .allowed  (src_allowed),
    .hit      (sel_hit),
    .win_idx  (sel_idx)
  );

  // Only table vectors leave the block, so reserved numbers cannot appear
  wire [5:0]  nxt_vec  = src_vector(sel_idx); // R3 R8 R15 R16 R17 R18 R19 R24
  wire [15:0] nxt_addr = advanced_mode ? {8'h00, nxt_vec, 2'b00}
                                       : {9'h000, nxt_vec, 1'b0}; // R20
  // Standby exit only from NMI and enabled lines 0 and 1
  wire nxt_wake = nmi_pend_ff | src_req[1] | src_req[2]; // R4

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_ff  <= 1'b0;
      irq_nmi_ff  <= 1'b0;
      irq_vec_ff  <= 6'h00;
      irq_addr_ff <= 16'h0000;
      wake_ff     <= 1'b0;
    end else begin
      irq_req_ff  <= sel_hit;
      irq_nmi_ff  <= sel_hit && sel_idx == '0; // R1
      irq_vec_ff  <= sel_hit ? nxt_vec : 6'h00;
      irq_addr_ff <= sel_hit ? nxt_addr : 16'h0000;
      wake_ff     <= nxt_wake;
    end
  end

  assign cpu_irq_req         = irq_req_ff;
  assign cpu_irq_is_nmi      = irq_nmi_ff;
  assign cpu_irq_vector      = irq_vec_ff;
  assign cpu_irq_vector_addr = irq_addr_ff;
  assign standby_wake        = wake_ff;

  // Read data mux
  logic [7:0] pend_view;
  always_comb begin
    pend_view = 8'h00;
    for (int k = 0; k < EXT_LINES; k++) begin
      pend_view[EXT_BIT[k]] = ext_flag[k];
    end
  end

  wire [31:0] rd_word =
    (s_axi_araddr == OFS_SYSCTL)  ? {24'h000000, system_control_reg_ff}    :
    (s_axi_araddr == OFS_SENSE)   ? {24'h000000, irq_sense_control_reg_ff} :
    (s_axi_araddr == OFS_ENABLE)  ? {24'h000000, irq_enable_reg_ff}        :
    (s_axi_araddr == OFS_PENDING) ? {24'h000000, pend_view}                : // R7
    (s_axi_araddr == OFS_PRIO_A)  ? {24'h000000, priority_reg_a_ff}        :
    (s_axi_araddr == OFS_PRIO_B)  ? {24'h000000, priority_reg_b_ff}        :
    (s_axi_araddr == OFS_VECTOR)  ? {8'h00, irq_addr_ff, irq_req_ff, irq_nmi_ff, irq_vec_ff} :
                                    32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : interrupt_source_vector_priority

// ==== src/isvp_pkg.sv ====
// Constants, register map and source table of the interrupt source block
package isvp_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_SYSCTL  = 8'h00;
  localparam logic [7:0] OFS_SENSE   = 8'h04;
  localparam logic [7:0] OFS_ENABLE  = 8'h08;
  localparam logic [7:0] OFS_PENDING = 8'h0c;
  localparam logic [7:0] OFS_PRIO_A  = 8'h10;
  localparam logic [7:0] OFS_PRIO_B  = 8'h14;
  localparam logic [7:0] OFS_VECTOR  = 8'h18;

  // Field positions in system_control_reg
  localparam int SYS_UE_BIT    = 3;
  localparam int SYS_NMI_EDGE_SELECT_BIT = 2;

  // Writable and readable bits of each register
  localparam logic [7:0] SYSCTL_MASK  = 8'h0c;
  localparam logic [7:0] SENSE_MASK   = 8'hff;
  localparam logic [7:0] IRQ_MASK     = 8'h33;
  localparam logic [7:0] PRIO_A_MASK  = 8'hdf;
  localparam logic [7:0] PRIO_B_MASK  = 8'hce;

  // Values after reset
  localparam logic [7:0] SYSCTL_RST   = 8'h08;
  localparam logic [7:0] REG_RST      = 8'h00;

  // External lines 0, 1, 4 and 5 sit at these register bit positions
  localparam int EXT_LINES = 4;
  localparam logic [2:0] EXT_BIT [EXT_LINES] = '{3'd0, 3'd1, 3'd4, 3'd5};

  // Sources in default order: NMI, 4 external, 25 internal
  localparam int NUM_INT  = 25;
  localparam int NUM_SRC  = 30;
  localparam int IDX_W    = 5;
  localparam int FIRST_INT = 5;

  localparam logic [5:0] NMI_VECTOR = 6'h07;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Vector number of a source; gaps never appear, so reserved vectors are unreachable
  function automatic logic [5:0] src_vector(input logic [IDX_W-1:0] idx);
    logic [5:0] v;
    v = 6'h00;
    case (idx)
      5'd0:                         v = NMI_VECTOR;
      5'd1:                         v = 6'h0c;
      5'd2:                         v = 6'h0d;
      5'd3:                         v = 6'h10;
      5'd4:                         v = 6'h11;
      5'd5:                         v = 6'h14;
      5'd6,  5'd7,  5'd8:           v = 6'(6'h18 + 6'(idx - 5'd6));
      5'd9,  5'd10, 5'd11:          v = 6'(6'h1c + 6'(idx - 5'd9));
      5'd12, 5'd13, 5'd14:          v = 6'(6'h20 + 6'(idx - 5'd12));
      5'd15, 5'd16, 5'd17:          v = 6'(6'h24 + 6'(idx - 5'd15));
      5'd18, 5'd19, 5'd20:          v = 6'(6'h28 + 6'(idx - 5'd18));
      5'd21, 5'd22, 5'd23, 5'd24,
      5'd25, 5'd26, 5'd27, 5'd28:   v = 6'(6'h34 + 6'(idx - 5'd21));
      5'd29:                        v = 6'h3c;
      default:                      v = 6'h00;
    endcase
    return v;
  endfunction : src_vector

  // Priority bit of a source: {1 = register B, bit index}
  function automatic logic [3:0] src_prio_sel(input logic [IDX_W-1:0] idx);
    logic [3:0] s;
    s = 4'h0;
    case (idx)
      5'd1:                  s = 4'h7;
      5'd2:                  s = 4'h6;
      5'd3,  5'd4:           s = 4'h4;
      5'd5:                  s = 4'h3;
      5'd6,  5'd7,  5'd8:    s = 4'h2;
      5'd9,  5'd10, 5'd11:   s = 4'h1;
      5'd12, 5'd13, 5'd14:   s = 4'h0;
      5'd15, 5'd16, 5'd17:   s = 4'hf;
      5'd18, 5'd19, 5'd20:   s = 4'he;
      5'd21, 5'd22, 5'd23, 5'd24: s = 4'hb;
      5'd25, 5'd26, 5'd27, 5'd28: s = 4'ha;
      5'd29:                 s = 4'h9;
      default:               s = 4'h0;
    endcase
    return s;
  endfunction : src_prio_sel

endpackage : isvp_pkg

// ==== src/ext_irq_line.sv ====
// One external request line: sense detection and pending flag
`timescale 1ns/1ps
module ext_irq_line
  import isvp_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin and controls
  input  wire logic pin_n,
  input  wire logic sense_edge,
  input  wire logic sw_clear,
  input  wire logic exc_clear,
  // Flag
  output logic      irq_pending_flag
);

  logic pin_prev_ff;
  logic flag_ff;
  logic set_req;
  logic clr_req;

  // Low level, or high-to-low change, per the sense bit
  assign set_req = sense_edge ? (pin_prev_ff & ~pin_n) : ~pin_n; // R5 R9
  // Exception clear in level mode only once the pin is back high
  assign clr_req = sw_clear | (exc_clear & (sense_edge | pin_n)); // R22

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_ff <= 1'b1;
      flag_ff     <= 1'b0;
    end else begin
      pin_prev_ff <= pin_n;
      // A new event wins over a clear in the same cycle
      flag_ff     <= set_req | (flag_ff & ~clr_req); // R7
    end
  end

  assign irq_pending_flag = flag_ff;

endmodule : ext_irq_line

// ==== src/irq_vector_select.sv ====
// Priority arbiter over all sources in default vector order
`timescale 1ns/1ps
module irq_vector_select
  import isvp_pkg::*;
(
  // Requests and their levels, index order is default order
  input  wire logic [NUM_SRC-1:0] req,
  input  wire logic [NUM_SRC-1:0] level_hi,
  input  wire logic [NUM_SRC-1:0] allowed,
  // Winner
  output logic                    hit,
  output logic [IDX_W-1:0]        win_idx
);

  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] live_hi;

  assign live    = req & allowed;
  // NMI forced into the top class so nothing outranks it
  assign live_hi = live & (level_hi | NUM_SRC'(1)); // R1 R21

  always_comb begin
    hit     = |live;
    win_idx = '0;
    // Downward scan leaves the smallest vector as winner
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (live[i] && live_hi == '0) begin
        win_idx = IDX_W'(i); // R12 R23
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (live_hi[i]) begin
        win_idx = IDX_W'(i); // R12 R23
      end
    end
  end

endmodule : irq_vector_select

// ==== verification/isvp_checker_asserts.sv ====
// Concurrent checks on the interrupt source block ports
`timescale 1ns/1ps
module isvp_checker
  import isvp_pkg::*;
(
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Read channel
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata,
  // Requests and CPU side
  input wire logic [NUM_INT-1:0] periph_req,
  input wire logic               ccr_i_bit,
  input wire logic               ccr_ui_bit,
  input wire logic               advanced_mode,
  input wire logic               cpu_irq_req,
  input wire logic               cpu_irq_is_nmi,
  input wire logic [5:0]         cpu_irq_vector,
  input wire logic [15:0]        cpu_irq_vector_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_nmi_vector: assert property (
    cpu_irq_is_nmi |-> cpu_irq_req && cpu_irq_vector == NMI_VECTOR)
    else $error("nmi vector wrong");
  chk_vector_addr: assert property (
    cpu_irq_req && $stable(advanced_mode) |-> cpu_irq_vector_addr ==
      (advanced_mode ? {8'h00, cpu_irq_vector, 2'b00} : {9'h000, cpu_irq_vector, 1'b0}))
    else $error("vector address wrong");
  chk_idle_zero: assert property (
    !cpu_irq_req |-> cpu_irq_vector == 6'h00 && cpu_irq_vector_addr == 16'h0000)
    else $error("idle vector not zero");
  chk_no_reserved: assert property (
    cpu_irq_req |-> !(cpu_irq_vector inside {14, 15, 18, 19, [21:23], 27, 31, 35, 39, [43:51]}))
    else $error("reserved vector selected");
  chk_masked_only_nmi: assert property (
    ccr_i_bit && ccr_ui_bit && $past(ccr_i_bit) && $past(ccr_ui_bit) && cpu_irq_req
      |-> cpu_irq_is_nmi)
    else $error("masked request passed");
  chk_periph_taken: assert property (
    (|periph_req && !ccr_i_bit) [*3] |-> cpu_irq_req)
    else $error("internal request lost");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : isvp_checker

bind interrupt_source_vector_priority isvp_checker u_chk (.*);

// ==== verification/cpu_model.sv ====
// Model of the CPU exception logic that takes requests
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Request from the block
  input  wire logic       ack_en,
  input  wire logic       cpu_irq_req,
  input  wire logic [5:0] cpu_irq_vector,
  // Acknowledge back
  output logic            exc_ack,
  output logic [5:0]      exc_ack_vector
);
  logic [1:0] hold_ff;
  wire        go = ack_en && cpu_irq_req && hold_ff == 2'd0 && !exc_ack;

  // Hold-off covers the flag clear latency, so one request is taken once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_ack <= 1'b0;
      exc_ack_vector <= 6'h3f;
      hold_ff <= 2'd0;
    end else begin
      exc_ack <= go;
      exc_ack_vector <= go ? cpu_irq_vector : ~exc_ack_vector;
      hold_ff <= go ? 2'd3 : hold_ff - 2'(hold_ff != 2'd0);
    end
  end
endmodule : cpu_model

// ==== verification/testbench.sv ====
// Self-checking bench of the interrupt source block
`timescale 1ns/1ps
module testbench;
  import isvp_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, nmi_pin, ccr_i_bit, ccr_ui_bit, advanced_mode, exc_ack;
  logic cpu_irq_req, cpu_irq_is_nmi, standby_wake, ack_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, b;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
  logic [3:0]  s_axi_wstrb, irq_pin_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [24:0] periph_req, r;
  logic [5:0]  exc_ack_vector, cpu_irq_vector, ev;
  logic [15:0] cpu_irq_vector_addr, pr;
  int failures, cmp_count, cycles;
  int vec_tab [NUM_SRC] = '{7, 12, 13, 16, 17, 20, 24, 25, 26, 28, 29, 30, 32, 33, 34,
                            36, 37, 38, 40, 41, 42, 52, 53, 54, 55, 56, 57, 58, 59, 60};
  // Bit of {priority_reg_b, priority_reg_a} giving each source its level
  int pbit_tab [NUM_SRC] = '{0, 7, 6, 4, 4, 3, 2, 2, 2, 1, 1, 1, 0, 0, 0,
                             15, 15, 15, 14, 14, 14, 11, 11, 11, 11, 10, 10, 10, 10, 9};
  logic [7:0] msk [6] = '{SYSCTL_MASK, SENSE_MASK, IRQ_MASK, 8'h00, PRIO_A_MASK, PRIO_B_MASK};

  interrupt_source_vector_priority dut (.*);
  cpu_model u_cpu (.aclk, .aresetn, .ack_en, .cpu_irq_req, .cpu_irq_vector, .exc_ack,
                   .exc_ack_vector);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand

  // NMI counts as level 1 and has the lowest index, so it always wins
  function automatic logic [5:0] exp_vec(input logic [NUM_SRC-1:0] q, input logic [15:0] p);
    int w;
    w = -1;
    for (int l = 0; l < 2; l++)
      for (int k = NUM_SRC - 1; k >= 0; k--)
        if (q[k] && (k == 0 || p[pbit_tab[k]]) == l[0]) w = k;
    return (w < 0) ? 6'h00 : 6'(vec_tab[w]);
  endfunction : exp_vec

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr

  // Ready is raised late on purpose so the held read data is exercised
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    if (er === RESP_OKAY) chk(s_axi_rdata, ex);
  endtask : rd

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    lfsr = 32'd18279;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, periph_req, nmi_pin} = '0;
    {ccr_i_bit, ccr_ui_bit, advanced_mode, ack_en, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    irq_pin_n = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), {24'h0, i == 0 ? SYSCTL_RST : REG_RST});
    for (int i = 0; i < 6; i++) begin
      wr(8'(4 * i), 8'hff);
      rd(8'(4 * i), {24'h0, msk[i]});
    end
    wr(8'h1c, 8'hff, RESP_SLVERR);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(OFS_SYSCTL, SYSCTL_RST);
    wr(OFS_SENSE, 8'h00);
    wr(OFS_ENABLE, 8'h00);
    $display("test registers done");
    for (int n = 0; n < 40; n++) begin
      lfsr = nxt_rand(lfsr);
      pr = lfsr[31:16] & {PRIO_B_MASK, PRIO_A_MASK};
      wr(OFS_PRIO_A, pr[7:0]);
      wr(OFS_PRIO_B, pr[15:8]);
      r = lfsr[24:0];
      lfsr = nxt_rand(lfsr);
      r = (n % 5 == 0) ? 25'h0 : (n == 1) ? 25'h1000000 : r & lfsr[24:0];
      periph_req <= r;
      advanced_mode <= lfsr[31];
      repeat (3) @(posedge aclk);
      ev = exp_vec({r, 5'h00}, pr);
      chk(cpu_irq_vector, ev);
      chk(cpu_irq_vector_addr, lfsr[31] ? 16'(ev) * 4 : 16'(ev) * 2);
    end
    $display("test priority done");
    periph_req <= '0;
    for (int e = 0; e < EXT_LINES; e++) begin
      b = 8'h01 << EXT_BIT[e];
      wr(OFS_SENSE, b);
      irq_pin_n[e] <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(cpu_irq_req, 1'b0);
      irq_pin_n[e] <= 1'b1;
      rd(OFS_PENDING, b);
      wr(OFS_PENDING, 8'h00);
      rd(OFS_PENDING, 32'h0);
      wr(OFS_ENABLE, b);
      wr(OFS_SENSE, 8'h00);
      irq_pin_n[e] <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(cpu_irq_vector, vec_tab[e + 1]);
      chk(standby_wake, 32'(e < 2));
      irq_pin_n[e] <= 1'b1;
      rd(OFS_PENDING, b);
      wr(OFS_PENDING, 8'h00);
      wr(OFS_ENABLE, 8'h00);
      chk(cpu_irq_req, 1'b0);
    end
    $display("test external lines done");
    periph_req <= '1;
    ccr_i_bit <= 1'b1;
    ccr_ui_bit <= 1'b1;
    nmi_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(cpu_irq_req, 1'b0);
    nmi_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(cpu_irq_vector, NMI_VECTOR);
    ack_en <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(cpu_irq_req, 1'b0);
    ack_en <= 1'b0;
    wr(OFS_SYSCTL, 8'h0c);
    nmi_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(cpu_irq_is_nmi, 1'b1);
    ack_en <= 1'b1;
    repeat (6) @(posedge aclk);
    ack_en <= 1'b0;
    $display("test nmi done");
    wr(OFS_SYSCTL, 8'h04);
    wr(OFS_PRIO_A, 8'h04);
    wr(OFS_PRIO_B, 8'h00);
    periph_req <= 25'h3;
    ccr_ui_bit <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(cpu_irq_vector, 6'd24);
    ccr_ui_bit <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(cpu_irq_req, 1'b0);
    wr(OFS_SYSCTL, 8'h08);
    ccr_ui_bit <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(cpu_irq_req, 1'b0);
    $display("test masking done");
    give_verdict();
  end
endmodule : testbench
